// >>> rtl/sramc_defs.vh
// What this block does
// - For every read the controller keeps write enable high for the whole cycle.
// - While select and output enable are low with write enable high the memory drives data, so the controller must not.
// - The address is valid no later than the write start and is held until the write ends.
// - Address set-up counts from address valid to write start and is never negative.
//
// Purpose: constants for the asynchronous static memory controller
// Assumes: core clock of 200 MHz
// Notes:   times are in picoseconds
`ifndef SRAMC_DEFS_VH
`define SRAMC_DEFS_VH
`define SRAMC_CLK_PS      5000
`define SRAMC_ADDR_W      18
`define SRAMC_DATA_W      16
`define SRAMC_WORDS       262144
`define SRAMC_WP_PS       10000
`define SRAMC_ACC_PS      15000
`define SRAMC_TURN_PS     7000
`define SRAMC_CNT_W       4
`define SRAMC_LO_LSB      0
`define SRAMC_HI_LSB      8
`endif

// >>> rtl/sramc_ctrl.v
// Purpose: host-side controller driving an asynchronous 256K x 16 SRAM
// Assumes: single clock, pins of the memory driven from flops
// Notes:   one access at a time; req is taken only while ready is high
`timescale 1ns/1ps
`include "sramc_defs.vh"
module sramc_ctrl #(
  parameter AW       = `SRAMC_ADDR_W,
  parameter DW       = `SRAMC_DATA_W,
  parameter WP_PS    = `SRAMC_WP_PS,
  parameter ACC_PS   = `SRAMC_ACC_PS,
  parameter TURN_PS  = `SRAMC_TURN_PS
) (
  input  wire          core_clk,
  input  wire          resetn,
  input  wire          req,
  input  wire          req_write,
  input  wire [AW-1:0] req_addr,
  input  wire [DW-1:0] req_wdata,
  input  wire [1:0]    req_be,
  output reg           ready,
  output reg           rd_valid,
  output reg  [DW-1:0] rd_data,
  output reg  [AW-1:0] mem_addr,
  output reg           mem_cs_n,
  output reg           mem_we_n,
  output reg           mem_oe_n,
  output reg           low_byte_sel_n,
  output reg           high_byte_sel_n,
  output reg  [DW-1:0] mem_dq_o,
  output reg  [DW-1:0] mem_dq_oe,
  input  wire [DW-1:0] mem_dq_i
);
  // Least times round up to whole cycles, at least one
  function [`SRAMC_CNT_W-1:0] cyc;
    input integer ps;
    integer c;
    begin
      c = (ps + `SRAMC_CLK_PS - 1) / `SRAMC_CLK_PS;
      if (c < 1)
        c = 1;
      cyc = c[`SRAMC_CNT_W-1:0];
    end
  endfunction
  localparam [`SRAMC_CNT_W-1:0] WP_CYC   = cyc(WP_PS);
  localparam [`SRAMC_CNT_W-1:0] ACC_CYC  = cyc(ACC_PS);
  localparam [`SRAMC_CNT_W-1:0] TURN_CYC = cyc(TURN_PS);
  localparam [`SRAMC_CNT_W-1:0] CNT_ONE  = 1;

  // Counter steps shared by the timed states
  function cnt_last;
    input [`SRAMC_CNT_W-1:0] n;
    begin
      cnt_last = (n <= CNT_ONE);
    end
  endfunction

  function [`SRAMC_CNT_W-1:0] cnt_dec;
    input [`SRAMC_CNT_W-1:0] n;
    begin
      cnt_dec = n - CNT_ONE;
    end
  endfunction

  // Access sequence, one access at a time.
  // Write: the cycle after the request, address, chip select, byte
  // selects and data are set with output enable high; the next cycle
  // the data drivers turn on and write enable falls, so the write
  // begins on write enable and address set-up is a full cycle.
  // Write enable stays low for the pulse count, then rises while
  // address and data still stand; one cycle later the drivers
  // release and chip select rises.
  // Read: address, chip select and output enable fall together, the
  // access count runs, then the synchronised data is taken once two
  // flop stages agree. The turnaround count lets the memory float
  // its outputs before a later write may drive the bus.
  // Limitation: a read whose word equals what the bus showed before
  // the access may be taken a cycle early; the access count already
  // covers the memory's access time by then.
  // Reset forces every strobe high and releases the drivers at once,
  // so a write cut by reset never reaches the array.
  // Byte enables of zero still pulse the strobes but write nothing.
  // The memory is fully static: no refresh or idle traffic.

  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_WSET  = 6'h02;
  localparam [5:0] S_WPUL  = 6'h04;
  localparam [5:0] S_WEND  = 6'h08;
  localparam [5:0] S_RACC  = 6'h10;
  localparam [5:0] S_TURN  = 6'h20;

  reg [5:0]              st_q;
  reg [`SRAMC_CNT_W-1:0] cnt_q;
  // Three-flop input path; second and third must agree
  reg [DW-1:0]           dq_s1_q;
  reg [DW-1:0]           dq_s2_q;
  reg [DW-1:0]           dq_s3_q;
  wire                   dq_stable;

  // Byte enables of the write in flight
  reg                    req_be_lo_q;
  reg                    req_be_hi_q;

  assign dq_stable = (dq_s2_q == dq_s3_q);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      dq_s1_q <= {DW{1'b0}};
      dq_s2_q <= {DW{1'b0}};
      dq_s3_q <= {DW{1'b0}};
    end else begin
      dq_s1_q <= mem_dq_i;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_q            <= S_IDLE;
      cnt_q           <= {`SRAMC_CNT_W{1'b0}};
      ready           <= 1'b0;
      rd_valid        <= 1'b0;
      rd_data         <= {DW{1'b0}};
      mem_addr        <= {AW{1'b0}};
      mem_cs_n        <= 1'b1;
      mem_we_n        <= 1'b1;
      mem_oe_n        <= 1'b1;
      low_byte_sel_n  <= 1'b1;
      high_byte_sel_n <= 1'b1;
      mem_dq_o        <= {DW{1'b0}};
      mem_dq_oe       <= {DW{1'b0}};
    end else begin
      rd_valid <= 1'b0;
      case (st_q)
        S_IDLE: begin
          // Requests are taken only while ready already stands
          ready <= 1'b1;
          if (req && ready) begin
            ready           <= 1'b0;
            mem_addr        <= req_addr;
            mem_cs_n        <= 1'b0;
            low_byte_sel_n  <= ~req_be[0];
            high_byte_sel_n <= ~req_be[1];
            cnt_q           <= CNT_ONE;
            if (req_write) begin
              // Address and select settle a cycle before the strobe
              mem_oe_n  <= 1'b1;
              mem_dq_o  <= req_wdata;
              st_q      <= S_WSET;
            end else begin
              mem_we_n  <= 1'b1;
              mem_oe_n  <= 1'b0;
              cnt_q     <= ACC_CYC;
              st_q      <= S_RACC;
            end
          end
        end
        S_WSET: begin
          // Drive data only once output enable is high: no contention
          mem_dq_oe <= {{`SRAMC_HI_LSB{req_be_hi_q}},
                        {`SRAMC_HI_LSB{req_be_lo_q}}};
          mem_we_n  <= 1'b0;
          cnt_q     <= WP_CYC;
          st_q      <= S_WPUL;
        end
        S_WPUL: begin
          // Strobe low for the pulse count; data stands throughout
          if (!cnt_last(cnt_q))
            cnt_q <= cnt_dec(cnt_q);
          else begin
            mem_we_n <= 1'b1;
            st_q     <= S_WEND;
          end
        end
        S_WEND: begin
          // Address and data held one cycle past the rising strobe
          mem_dq_oe       <= {DW{1'b0}};
          mem_cs_n        <= 1'b1;
          low_byte_sel_n  <= 1'b1;
          high_byte_sel_n <= 1'b1;
          ready           <= 1'b1;
          st_q            <= S_IDLE;
        end
        S_RACC: begin
          // Access time first, then wait for the synchroniser to agree
          // so a word in mid-change is never captured
          if (!cnt_last(cnt_q))
            cnt_q <= cnt_dec(cnt_q);
          else if (dq_stable) begin
            rd_data  <= dq_s3_q;
            rd_valid <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_cs_n <= 1'b1;
            low_byte_sel_n  <= 1'b1;
            high_byte_sel_n <= 1'b1;
            cnt_q    <= TURN_CYC;
            st_q     <= S_TURN;
          end
        end
        S_TURN: begin
          // Memory output must float before anyone drives again
          if (!cnt_last(cnt_q))
            cnt_q <= cnt_dec(cnt_q);
          else begin
            ready <= 1'b1;
            st_q  <= S_IDLE;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      req_be_lo_q <= 1'b0;
      req_be_hi_q <= 1'b0;
    end else if (st_q == S_IDLE && req && ready) begin
      req_be_lo_q <= req_be[0];
      req_be_hi_q <= req_be[1];
    end
  end
endmodule

// >>> dv/sramc_mem_model.sv
// Purpose: memory model. Assumes: no timing. Notes: floats read inverted
`timescale 1ns/1ps
module sramc_mem_model(
  input  wire [17:0] addr,
  input  wire        cs_n,
  input  wire        we_n,
  input  wire        oe_n,
  input  wire        low_byte_sel_n,
  input  wire        high_byte_sel_n,
  input  wire [15:0] din,
  output reg  [15:0] dout
);
  reg  [15:0] mem [0:262143];
  wire        wr_on = !cs_n && !we_n;
  wire        rd_on = !cs_n && we_n && !oe_n;
  always @(negedge wr_on) begin
    if (!low_byte_sel_n) mem[addr][7:0] = din[7:0];
    if (!high_byte_sel_n) mem[addr][15:8] = din[15:8];
  end
  // A floating lane shows the inverse so stale data never passes
  always @* begin
    dout[7:0] = (rd_on && !low_byte_sel_n) ? mem[addr][7:0]
                                           : ~mem[addr][7:0];
    dout[15:8] = (rd_on && !high_byte_sel_n) ? mem[addr][15:8]
                                             : ~mem[addr][15:8];
  end
endmodule

// >>> dv/sramc_ctrl_assertions.sv
// Purpose: pin checks. Assumes: one clock. Notes: widths fixed
`timescale 1ns/1ps
module sramc_ctrl_assertions(
  input wire        core_clk,
  input wire        resetn,
  input wire [17:0] mem_addr,
  input wire        mem_cs_n,
  input wire        mem_we_n,
  input wire        mem_oe_n,
  input wire [15:0] mem_dq_oe,
  input wire        rd_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_rd_we; !mem_cs_n && !mem_oe_n |-> mem_we_n; endproperty
  a_rd_we: assert property (p_rd_we) else $error("we low in read");
  property p_fight; !mem_cs_n && !mem_oe_n |-> mem_dq_oe == 16'h0000;
  endproperty
  a_fight: assert property (p_fight) else $error("bus fight");
  property p_hold; !mem_cs_n && !mem_we_n |=> mem_we_n || $stable(mem_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("addr moved");
  property p_setup; $fell(mem_we_n) |-> !mem_cs_n && $stable(mem_addr);
  endproperty
  a_setup: assert property (p_setup) else $error("no setup");
  property p_wpulse;
    $fell(mem_we_n) |-> (!mem_cs_n && !mem_we_n)[*2] ##1 mem_we_n;
  endproperty
  a_wpulse: assert property (p_wpulse) else $error("bad pulse");
  cover property ($fell(mem_we_n));
  cover property (rd_valid);
  cover property ($rose(mem_cs_n));
endmodule
bind sramc_ctrl sramc_ctrl_assertions chk (.core_clk(core_clk),
  .resetn(resetn), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n),
  .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_dq_oe(mem_dq_oe),
  .rd_valid(rd_valid));

// >>> dv/sramc_ctrl_tb.sv
// Purpose: bench. Assumes: 200 MHz. Notes: no random stimulus
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((e) !== (s)) begin n_fail++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module sramc_ctrl_tb;
  reg         core_clk = 0, resetn = 0, req = 0, req_write = 0;
  reg  [17:0] req_addr = 0;
  reg  [15:0] req_wdata = 0, d;
  reg  [1:0]  req_be = 0;
  wire        ready, rd_valid, cs_n, we_n, oe_n;
  wire        low_byte_sel_n, high_byte_sel_n;
  wire [17:0] addr;
  wire [15:0] rd_data, dq_o, dq_oe, dq_i;
  integer     n_fail = 0, n_compared = 0, k;
  always #2.5 core_clk = ~core_clk;
  sramc_ctrl uut (.core_clk(core_clk), .resetn(resetn), .req(req),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_be(req_be), .ready(ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .mem_addr(addr), .mem_cs_n(cs_n), .mem_we_n(we_n), .mem_oe_n(oe_n),
    .low_byte_sel_n(low_byte_sel_n), .high_byte_sel_n(high_byte_sel_n),
    .mem_dq_o(dq_o), .mem_dq_oe(dq_oe), .mem_dq_i(dq_i));
  sramc_mem_model mem (.addr(addr), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n),
    .low_byte_sel_n(low_byte_sel_n), .high_byte_sel_n(high_byte_sel_n),
    .din(dq_o & dq_oe), .dout(dq_i));
  task wrap_up;
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task access(input w, input [17:0] a, input [15:0] v, input [1:0] be);
    begin
      // Look past the edge that took the last request before waiting
      @(negedge core_clk);
      for (k = 0; ready !== 1'b1 && k < 99; k++) @(negedge core_clk);
      if (k == 99) begin n_fail++; wrap_up; end
      @(posedge core_clk);
      {req, req_write, req_addr, req_wdata, req_be} <= {1'b1, w, a, v, be};
      @(posedge core_clk);
      req <= 1'b0;
    end
  endtask
  task rd(input [17:0] a, input [15:0] e);
    begin
      access(0, a, 16'h0000, 2'h3);
      for (k = 0; rd_valid !== 1'b1 && k < 99; k++) @(negedge core_clk);
      if (k == 99) begin n_fail++; wrap_up; end
      `CHK("rd_data", e, rd_data)
    end
  endtask
  task sc_word;
    begin
      access(1, 18'h3FFFF, 16'hA5C3, 2'h3);
      access(1, 18'h00000, 16'h5A3C, 2'h3);
      rd(18'h3FFFF, 16'hA5C3);
      rd(18'h00000, 16'h5A3C);
    end
  endtask
  task sc_lanes;
    begin
      access(1, 18'h00010, 16'h1234, 2'h3);
      access(1, 18'h00010, 16'hABCD, 2'h1);
      rd(18'h00010, 16'h12CD);
      access(1, 18'h00010, 16'h55AA, 2'h2);
      access(1, 18'h00010, 16'hFFFF, 2'h0);
      rd(18'h00010, 16'h55CD);
    end
  endtask
  // Reset lands on the edge where write enable falls, so the word must survive
  task sc_reset;
    begin
      access(1, 18'h00010, 16'h0000, 2'h3);
      @(posedge core_clk);
      resetn <= 1'b0;
      @(negedge core_clk);
      `CHK("cs_n", 1'b1, cs_n)
      `CHK("dq_oe", 16'h0000, dq_oe)
      @(posedge core_clk);
      resetn <= 1'b1;
      rd(18'h00010, 16'h55CD);
    end
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    sc_word;
    sc_lanes;
    sc_reset;
    wrap_up;
  end
endmodule
